// *** rtl/anrl_cfg.svh ***
`ifndef ANRL_CFG_SVH
`define ANRL_CFG_SVH

// configuration register numbers
`define ANRL_ADDR_NODE_ID 8'h05
`define ANRL_ADDR_RST_MODE 8'h50
`define ANRL_ADDR_FREQ 8'h51
`define ANRL_ADDR_LINK 8'h80

// node identifier
`define ANRL_NODE_ID_HI 15
`define ANRL_NODE_ID_RST 16'h0000

// reset and mode control fields
`define ANRL_RM_SYS_BIT 0
`define ANRL_RM_TILE_BIT 1
`define ANRL_RM_MODE_HI 17
`define ANRL_RM_MODE_LO 16
`define ANRL_RM_TRI_BIT 24
`define ANRL_MODE_RST 2'h0
`define ANRL_TRI_RST 1'h0

// oscillator frequency field, MHz
`define ANRL_FREQ_HI 6
`define ANRL_FREQ_RST 7'h19
`define ANRL_FREQ_MIN 7'h05
`define ANRL_FREQ_MAX 7'h64

// link control and status fields
`define ANRL_LK_ERR_BIT 27
`define ANRL_LK_GRANT_BIT 26
`define ANRL_LK_HELD_BIT 25
`define ANRL_LK_INIT_BIT 24
`define ANRL_LK_RESYNC_BIT 23
`define ANRL_LK_SYM_HI 21
`define ANRL_LK_SYM_LO 11
`define ANRL_LK_TOK_HI 10
`define ANRL_LK_TOK_LO 0
`define ANRL_GAP_RST 11'h001

// timing
`define ANRL_SYS_RST_CYCLES 32'h0008_0000
`define ANRL_TILE_RST_US 10'h00a
`define ANRL_TICK_US 10'h3e8
`define ANRL_TOK_EDGES 4'h4

`endif

// *** rtl/anrl_hold_timer.sv ***
`timescale 1ns/1ps
module anrl_hold_timer #(
  parameter int W = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trig,
  input wire logic [W-1:0] len,
  output logic active_q
);
  logic [W-1:0] cnt_q;

  // held while trig stands, then len further cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      active_q <= 1'b0;
    end else if (trig) begin
      cnt_q <= len;
      active_q <= 1'b1;
    end else if (cnt_q > W'(1)) begin
      cnt_q <= cnt_q - W'(1);
    end else begin
      cnt_q <= '0;
      active_q <= 1'b0;
    end
  end
endmodule

// *** rtl/anrl_pace_if.sv ***
`timescale 1ns/1ps
interface anrl_pace_if;
  logic tok_valid;
  logic tok_ready;
  anrl_pkg::anrl_gap_t sym_gap;
  anrl_pkg::anrl_gap_t tok_gap;
  modport src (
    output tok_valid,
    output sym_gap,
    output tok_gap,
    input tok_ready
  );
  modport pacer (
    input tok_valid,
    input sym_gap,
    input tok_gap,
    output tok_ready
  );
endinterface

// *** rtl/anrl_pkg.sv ***
package anrl_pkg;
  typedef enum logic [1:0] {PACE_IDLE, PACE_SYM, PACE_GAP} anrl_pace_e;
  typedef logic [10:0] anrl_gap_t;
  typedef logic [31:0] anrl_word_t;
endpackage

// *** rtl/anrl_tok_pacer.sv ***
`timescale 1ns/1ps
`include "anrl_cfg.svh"
module anrl_tok_pacer (
  input wire logic clock,
  input wire logic rst_n,
  anrl_pace_if.pacer pc,
  output logic link_tx_wire
);
  anrl_pkg::anrl_pace_e state_q;
  anrl_pkg::anrl_gap_t gap_q;
  logic [3:0] edges_q;
  logic [11:0] since_q;
  logic done_gap;
  logic take;
  logic step;

  assign done_gap = (gap_q <= 11'h001);
  assign pc.tok_ready = (state_q == anrl_pkg::PACE_IDLE) ||
                        ((state_q == anrl_pkg::PACE_GAP) && done_gap);
  assign take = pc.tok_valid && pc.tok_ready;
  assign step = (state_q == anrl_pkg::PACE_SYM) && done_gap;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= anrl_pkg::PACE_IDLE;
      gap_q <= 11'h000;
      edges_q <= 4'h0;
    end else if (take) begin
      state_q <= anrl_pkg::PACE_SYM;
      gap_q <= pc.sym_gap;
      edges_q <= 4'h1;
    end else begin
      unique case (state_q)
        anrl_pkg::PACE_IDLE: begin
          gap_q <= 11'h000;
        end
        anrl_pkg::PACE_SYM: begin
          if (!done_gap) begin
            gap_q <= gap_q - 11'h001;
          end else if (edges_q + 4'h1 == `ANRL_TOK_EDGES) begin
            state_q <= anrl_pkg::PACE_GAP;
            gap_q <= pc.tok_gap;
            edges_q <= edges_q + 4'h1;
          end else begin
            gap_q <= pc.sym_gap;
            edges_q <= edges_q + 4'h1;
          end
        end
        anrl_pkg::PACE_GAP: begin
          if (!done_gap) begin
            gap_q <= gap_q - 11'h001;
          end else begin
            state_q <= anrl_pkg::PACE_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_tx_wire <= 1'b0;
    end else if (take || step) begin
      link_tx_wire <= ~link_tx_wire;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since_q <= 12'h000;
    end else if (take || step) begin
      since_q <= 12'h001;
    end else if (since_q != 12'hfff) begin
      since_q <= since_q + 12'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sym_space_a: assert property (
    step |-> since_q == ((pc.sym_gap == 11'h000) ? 12'h001 :
                          {1'b0, pc.sym_gap}))
    else $error("transition spacing differs from setting");
  tok_space_a: assert property (
    (take && state_q == anrl_pkg::PACE_GAP) |->
      since_q == ((pc.tok_gap == 11'h000) ? 12'h001 : {1'b0, pc.tok_gap}))
    else $error("token spacing differs from setting");
endmodule

// *** rtl/anrl_top.sv ***
// Function
// - sixteen-bit node identifier, resets zero, unused
// - pin, brown-out or watchdog start system reset
// - sleep or clock change reset tile only
// - system reset clears config fields, link flags and tiles, tile reset tiles
// - system reset lasts 524,288 oscillator cycles
// - bit 1 write starts tile reset, self-clearing
// - reset-bit writes get no response packet
// - mode pins field and tristate bit
// - seven-bit frequency field, resets to 25
// - frequency outside 5..100 not stored and NACKed
// - tile reset and tick timings derive from programmed frequency
// - error bit set on overflow, read clears
// - status bits for credit granted and held
// - resync bit resets receiver token alignment
// - transition spacing from bits 21:11
// - token spacing from bits 10:0
`timescale 1ns/1ps
`include "anrl_cfg.svh"
module anrl_top #(
  parameter int unsigned SYS_RST_CYCLES = `ANRL_SYS_RST_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cfg_req_valid,
  input wire logic cfg_req_write,
  input wire logic [7:0] cfg_req_addr,
  input wire logic [31:0] cfg_req_wdata,
  input wire logic cfg_req_resp,
  output logic cfg_rsp_valid,
  output logic cfg_rsp_nack,
  output logic [31:0] cfg_rsp_rdata,
  input wire logic ext_rst_pin_n,
  input wire logic brownout_pin,
  input wire logic wdog_expire,
  input wire logic sleep_evt,
  input wire logic clk_src_evt,
  output logic sys_reset,
  output logic tile_reset,
  output logic ms_tick,
  output logic [1:0] mode_pin_o,
  output logic mode_pin_oe_n,
  input wire logic rx_hello,
  input wire logic rx_credit,
  input wire logic rx_error,
  output logic rx_resync,
  input wire logic tx_token_req,
  output logic tx_token_ack,
  output logic link_tx_wire
);
  localparam int SYS_W = $clog2(SYS_RST_CYCLES + 1);
  localparam logic [SYS_W-1:0] SYS_LEN = SYS_W'(SYS_RST_CYCLES);

  logic rst_meta_q;
  logic rst_n;
  logic ext_meta_q;
  logic ext_sync_q;
  logic bo_meta_q;
  logic bo_sync_q;
  logic wr;
  logic rd;
  logic rst_wr;
  logic lk_init;
  logic sys_sw_q;
  logic tile_sw_q;
  logic sys_trig;
  logic tile_trig;
  logic [15:0] node_id_q;
  logic [1:0] mode_q;
  logic tri_q;
  logic [6:0] freq_q;
  anrl_pkg::anrl_gap_t sym_gap_q;
  anrl_pkg::anrl_gap_t tok_gap_q;
  logic err_q;
  logic held_q;
  logic granted_q;
  logic hello_pend_q;
  logic credit_pend_q;
  logic take;
  logic known;
  anrl_pkg::anrl_word_t rd_word;
  logic [16:0] tick_cnt_q;
  logic [SYS_W-1:0] sys_run_q;

  anrl_pace_if pc ();

  function automatic logic freq_ok(input logic [31:0] w);
    freq_ok = (w[31:`ANRL_FREQ_HI+1] == 25'h0000000) &&
              (w[`ANRL_FREQ_HI:0] >= `ANRL_FREQ_MIN) &&
              (w[`ANRL_FREQ_HI:0] <= `ANRL_FREQ_MAX);
  endfunction

  // cycles in a span of us microseconds at mhz
  function automatic logic [16:0] cyc_of(input logic [6:0] mhz,
                                         input logic [9:0] us);
    cyc_of = {10'h000, mhz} * {7'h00, us};
  endfunction

  // reset release through two flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta_q <= 1'b1;
      ext_sync_q <= 1'b1;
      bo_meta_q <= 1'b0;
      bo_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_rst_pin_n;
      ext_sync_q <= ext_meta_q;
      bo_meta_q <= brownout_pin;
      bo_sync_q <= bo_meta_q;
    end
  end

  assign wr = cfg_req_valid && cfg_req_write;
  assign rd = cfg_req_valid && !cfg_req_write;
  assign rst_wr = wr && (cfg_req_addr == `ANRL_ADDR_RST_MODE) &&
                  (cfg_req_wdata[`ANRL_RM_SYS_BIT] ||
                   cfg_req_wdata[`ANRL_RM_TILE_BIT]);
  assign lk_init = wr && (cfg_req_addr == `ANRL_ADDR_LINK) &&
                   cfg_req_wdata[`ANRL_LK_INIT_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_sw_q <= 1'b0;
      tile_sw_q <= 1'b0;
    end else begin
      sys_sw_q <= wr && (cfg_req_addr == `ANRL_ADDR_RST_MODE) &&
                  cfg_req_wdata[`ANRL_RM_SYS_BIT];
      tile_sw_q <= wr && (cfg_req_addr == `ANRL_ADDR_RST_MODE) &&
                   cfg_req_wdata[`ANRL_RM_TILE_BIT];
    end
  end

  assign sys_trig = !ext_sync_q || bo_sync_q || wdog_expire || sys_sw_q;
  assign tile_trig = tile_sw_q || sleep_evt || clk_src_evt || sys_reset;

  anrl_hold_timer #(.W(SYS_W)) u_sys_timer (
    .clock(clock),
    .rst_n(rst_n),
    .trig(sys_trig),
    .len(SYS_LEN),
    .active_q(sys_reset)
  );

  anrl_hold_timer #(.W(17)) u_tile_timer (
    .clock(clock),
    .rst_n(rst_n),
    .trig(tile_trig),
    .len(cyc_of(freq_q, `ANRL_TILE_RST_US)),
    .active_q(tile_reset)
  );

  // millisecond tick for watchdog and clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 17'h00000;
      ms_tick <= 1'b0;
    end else if (tick_cnt_q + 17'h00001 >= cyc_of(freq_q, `ANRL_TICK_US)) begin
      tick_cnt_q <= 17'h00000;
      ms_tick <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h00001;
      ms_tick <= 1'b0;
    end
  end

  // writable fields, cleared by system reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      node_id_q <= `ANRL_NODE_ID_RST;
      mode_q <= `ANRL_MODE_RST;
      tri_q <= `ANRL_TRI_RST;
      sym_gap_q <= `ANRL_GAP_RST;
      tok_gap_q <= `ANRL_GAP_RST;
    end else if (sys_reset) begin
      node_id_q <= `ANRL_NODE_ID_RST;
      mode_q <= `ANRL_MODE_RST;
      tri_q <= `ANRL_TRI_RST;
      sym_gap_q <= `ANRL_GAP_RST;
      tok_gap_q <= `ANRL_GAP_RST;
    end else if (wr) begin
      if (cfg_req_addr == `ANRL_ADDR_NODE_ID) begin
        node_id_q <= cfg_req_wdata[`ANRL_NODE_ID_HI:0];
      end
      if (cfg_req_addr == `ANRL_ADDR_RST_MODE) begin
        mode_q <= cfg_req_wdata[`ANRL_RM_MODE_HI:`ANRL_RM_MODE_LO];
        tri_q <= cfg_req_wdata[`ANRL_RM_TRI_BIT];
      end
      if (cfg_req_addr == `ANRL_ADDR_LINK) begin
        sym_gap_q <= cfg_req_wdata[`ANRL_LK_SYM_HI:`ANRL_LK_SYM_LO];
        tok_gap_q <= cfg_req_wdata[`ANRL_LK_TOK_HI:`ANRL_LK_TOK_LO];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      freq_q <= `ANRL_FREQ_RST;
    end else if (sys_reset) begin
      freq_q <= `ANRL_FREQ_RST;
    end else if (wr && (cfg_req_addr == `ANRL_ADDR_FREQ) &&
                 freq_ok(cfg_req_wdata)) begin
      freq_q <= cfg_req_wdata[`ANRL_FREQ_HI:0];
    end
  end

  // mode pins driven unless tristated; oe is active low
  assign mode_pin_o = mode_q;
  assign mode_pin_oe_n = tri_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_resync <= 1'b0;
    end else begin
      rx_resync <= wr && (cfg_req_addr == `ANRL_ADDR_LINK) &&
                   cfg_req_wdata[`ANRL_LK_RESYNC_BIT];
    end
  end

  // sticky error, new event beats the read clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (rx_error) begin
      err_q <= 1'b1;
    end else if (sys_reset || (rd && cfg_req_addr == `ANRL_ADDR_LINK)) begin
      err_q <= 1'b0;
    end
  end

  // hello first, then owed credit, then user data on credit
  assign pc.tok_valid = hello_pend_q || credit_pend_q ||
                        (tx_token_req && held_q);
  assign pc.sym_gap = sym_gap_q;
  assign pc.tok_gap = tok_gap_q;
  assign take = pc.tok_valid && pc.tok_ready;

  // credit held, arriving credit beats init clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 1'b0;
    end else if (sys_reset) begin
      held_q <= 1'b0;
    end else if (rx_credit) begin
      held_q <= 1'b1;
    end else if (lk_init) begin
      held_q <= 1'b0;
    end
  end

  // hello pending until pacer accepts it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hello_pend_q <= 1'b0;
    end else if (sys_reset) begin
      hello_pend_q <= 1'b0;
    end else if (lk_init) begin
      hello_pend_q <= 1'b1;
    end else if (take) begin
      hello_pend_q <= 1'b0;
    end
  end

  // remote hello owes it credit; granted once sent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      credit_pend_q <= 1'b0;
      granted_q <= 1'b0;
    end else if (sys_reset) begin
      credit_pend_q <= 1'b0;
      granted_q <= 1'b0;
    end else begin
      if (rx_hello) begin
        credit_pend_q <= 1'b1;
      end else if (take && !hello_pend_q) begin
        credit_pend_q <= 1'b0;
      end
      if (take && !hello_pend_q && credit_pend_q) begin
        granted_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_token_ack <= 1'b0;
    end else begin
      tx_token_ack <= take && !hello_pend_q && !credit_pend_q;
    end
  end

  anrl_tok_pacer u_pacer (
    .clock(clock),
    .rst_n(rst_n),
    .pc(pc.pacer),
    .link_tx_wire(link_tx_wire)
  );

  // write-only bits read as zero
  always_comb begin
    known = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (cfg_req_addr)
      `ANRL_ADDR_NODE_ID: rd_word[`ANRL_NODE_ID_HI:0] = node_id_q;
      `ANRL_ADDR_RST_MODE: begin
        rd_word[`ANRL_RM_MODE_HI:`ANRL_RM_MODE_LO] = mode_q;
        rd_word[`ANRL_RM_TRI_BIT] = tri_q;
      end
      `ANRL_ADDR_FREQ: rd_word[`ANRL_FREQ_HI:0] = freq_q;
      `ANRL_ADDR_LINK: begin
        rd_word[`ANRL_LK_ERR_BIT] = err_q;
        rd_word[`ANRL_LK_GRANT_BIT] = granted_q;
        rd_word[`ANRL_LK_HELD_BIT] = held_q;
        rd_word[`ANRL_LK_SYM_HI:`ANRL_LK_SYM_LO] = sym_gap_q;
        rd_word[`ANRL_LK_TOK_HI:`ANRL_LK_TOK_LO] = tok_gap_q;
      end
      default: known = 1'b0;
    endcase
  end

  // answer one cycle after the request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rsp_valid <= 1'b0;
      cfg_rsp_nack <= 1'b0;
      cfg_rsp_rdata <= 32'h0000_0000;
    end else begin
      cfg_rsp_valid <= cfg_req_valid && cfg_req_resp && !rst_wr;
      cfg_rsp_nack <= cfg_req_valid && (!known ||
                      (wr && cfg_req_addr == `ANRL_ADDR_FREQ &&
                       !freq_ok(cfg_req_wdata)));
      cfg_rsp_rdata <= rd ? rd_word : 32'h0000_0000;
    end
  end

  // system reset cycles counted since the last system reset trigger
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_run_q <= '0;
    end else if (sys_trig) begin
      sys_run_q <= '0;
    end else if (sys_reset) begin
      sys_run_q <= sys_run_q + SYS_W'(1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence tile_wr_s;
    wr && cfg_req_addr == `ANRL_ADDR_RST_MODE &&
      cfg_req_wdata[`ANRL_RM_TILE_BIT];
  endsequence
  sequence sys_wr_s;
    wr && cfg_req_addr == `ANRL_ADDR_RST_MODE &&
      cfg_req_wdata[`ANRL_RM_SYS_BIT];
  endsequence
  sequence bad_freq_s;
    wr && cfg_req_resp && cfg_req_addr == `ANRL_ADDR_FREQ &&
      !freq_ok(cfg_req_wdata) && !sys_reset;
  endsequence

  rst_vals_a: assert property (
    $fell(sys_reset) |-> freq_q == `ANRL_FREQ_RST &&
                         node_id_q == `ANRL_NODE_ID_RST)
    else $error("fields not at reset value after system reset");
  brownout_rst_a: assert property (
    brownout_pin |-> ##3 sys_reset)
    else $error("brown-out did not start system reset");
  sleep_tile_a: assert property (
    (sleep_evt && !sys_trig && !sys_reset) |=> tile_reset && !sys_reset)
    else $error("sleep event reset scope wrong");
  sys_covers_a: assert property (
    sys_reset |=> tile_reset)
    else $error("tile not reset during system reset");
  sys_len_a: assert property (
    $fell(sys_reset) |-> sys_run_q == SYS_LEN)
    else $error("system reset length wrong");
  tile_sw_a: assert property (
    tile_wr_s |-> ##2 tile_reset)
    else $error("tile reset write had no effect");
  sys_sw_a: assert property (
    sys_wr_s |-> ##2 sys_reset)
    else $error("system reset write had no effect");
  rst_silent_a: assert property (
    rst_wr |=> !cfg_rsp_valid)
    else $error("reset write answered");
  mode_pins_a: assert property (
    (wr && cfg_req_addr == `ANRL_ADDR_RST_MODE && !sys_reset) |=>
      mode_pin_o == $past(cfg_req_wdata[`ANRL_RM_MODE_HI:`ANRL_RM_MODE_LO])
      && mode_pin_oe_n == $past(cfg_req_wdata[`ANRL_RM_TRI_BIT]))
    else $error("mode pins do not follow write");
  freq_nack_a: assert property (
    bad_freq_s |=> cfg_rsp_valid && cfg_rsp_nack && $stable(freq_q))
    else $error("bad frequency not refused");
  err_sticky_a: assert property (
    rx_error |=> err_q ##1 (err_q || $past(sys_reset) ||
      $past(rd && cfg_req_addr == `ANRL_ADDR_LINK)))
    else $error("link error flag lost");
  grant_a: assert property (
    (take && !hello_pend_q && credit_pend_q && !sys_reset) |=> granted_q)
    else $error("granted flag not set after credit sent");
  // init clears credit and queues hello
  init_a: assert property (
    (lk_init && !rx_credit && !sys_reset) |=> !held_q && hello_pend_q)
    else $error("link init did not clear credit");
  resync_a: assert property (
    (wr && cfg_req_addr == `ANRL_ADDR_LINK &&
     cfg_req_wdata[`ANRL_LK_RESYNC_BIT]) |=> rx_resync ##1 !rx_resync ||
     $past(wr))
    else $error("resync strobe missing");
endmodule

// *** testbench/analog_node_reset_link_config_tb.sv ***
`timescale 1ns/1ps
module analog_node_reset_link_config_tb;
  logic clock, reset_n, cfg_req_valid, cfg_req_write, cfg_req_resp;
  logic [7:0] cfg_req_addr;
  logic [31:0] cfg_req_wdata, cfg_rsp_rdata, m, md;
  logic cfg_rsp_valid, cfg_rsp_nack, ext_rst_pin_n, brownout_pin;
  logic wdog_expire, sleep_evt, clk_src_evt, sys_reset, tile_reset;
  logic ms_tick, mode_pin_oe_n, rx_hello, rx_credit, rx_error, rx_resync;
  logic tx_token_req, tx_token_ack, link_tx_wire, hello_cmd;
  logic [1:0] mode_pin_o;
  logic [32:0] exp_q[$];
  logic [6:0] fv[5];
  logic [6:0] cur;
  int n_errors, cmp_count, n_sync, nt, ns, c;

  anrl_top #(.SYS_RST_CYCLES(64)) anrl_top_i (.*);
  anrl_remote_end anrl_remote_end_i (.clock(clock), .reset_n(reset_n),
    .link_tx_wire(link_tx_wire), .hello_cmd(hello_cmd),
    .rx_hello(rx_hello), .rx_credit(rx_credit));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // reset-bit writes to 0x50 are never answered
  task automatic cfg(input int wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    cfg_req_valid = 1'b1;
    cfg_req_write = wr[0];
    cfg_req_addr = a;
    cfg_req_wdata = d;
    cfg_req_resp = 1'b1;
    if (!(wr[0] && a == 8'h50 && d[1:0] != 2'h0)) exp_q.push_back(e);
    @(negedge clock);
    cfg_req_valid = 1'b0;
    @(negedge clock);
  endtask

  task automatic meas;
    nt = 0;
    ns = 0;
    repeat (400) begin
      if (tile_reset === 1'b1) nt++;
      if (sys_reset === 1'b1) ns++;
      @(negedge clock);
    end
  endtask

  task automatic tog;
    logic w;
    w = link_tx_wire;
    c = 0;
    while (link_tx_wire === w && c < 100) begin
      @(negedge clock);
      c++;
    end
  endtask

  always @(negedge clock) begin
    if (rx_resync === 1'b1) n_sync++;
    if (cfg_rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b1, 1'b0);
      else chk({cfg_rsp_nack, cfg_rsp_rdata}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    test_done();
  end

  initial begin
    {cfg_req_valid, cfg_req_write, cfg_req_resp, reset_n} = 4'h0;
    {cfg_req_addr, cfg_req_wdata, rx_error, tx_token_req} = 42'h0;
    {brownout_pin, wdog_expire, sleep_evt, clk_src_evt} = 4'h0;
    {ext_rst_pin_n, hello_cmd} = 2'h2;
    n_errors = 0;
    cmp_count = 0;
    n_sync = 0;
    void'($urandom(32'hba283cb6));
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    cfg(0, 8'h05, 0, 33'h0);
    cfg(0, 8'h50, 0, 33'h0);
    cfg(0, 8'h51, 0, 33'h19);
    cfg(0, 8'h80, 0, 33'h801);
    cfg(0, 8'h33, 0, {1'b1, 32'h0});
    m = $urandom;
    cfg(1, 8'h05, m, 33'h0);
    cfg(0, 8'h05, 0, {17'h0, m[15:0]});
    fv = '{7'h04, 7'h05, 7'h64, 7'h65, 7'h05 + 7'($urandom_range(95))};
    cur = 7'h19;
    foreach (fv[i]) begin
      cfg(1, 8'h51, {25'h0, fv[i]},
          {fv[i] < 5 || fv[i] > 100, 32'h0});
      if (fv[i] >= 5 && fv[i] <= 100) cur = fv[i];
      cfg(0, 8'h51, 0, {26'h0, cur});
    end
    cfg(1, 8'h51, 32'h5, 33'h0);
    for (int i = 0; i < 2; i++) begin
      m = $urandom;
      md = (m & 32'h0003_0000) | (i == 1 ? 32'h0100_0000 : 32'h0);
      cfg(1, 8'h50, md, 33'h0);
      cfg(0, 8'h50, 0, {1'b0, md});
      chk(mode_pin_o, m[17:16]);
      chk(mode_pin_oe_n, i[0]);
    end
    cfg(1, 8'h50, md | 32'h2, 33'h0);
    meas();
    chk(nt >= 50 && nt <= 51 && ns == 0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) sleep_evt = 1'b1;
      else clk_src_evt = 1'b1;
      @(negedge clock);
      {sleep_evt, clk_src_evt} = 2'h0;
      meas();
      chk(nt >= 49 && nt <= 51 && ns == 0, 1'b1);
    end
    cfg(0, 8'h50, 0, {1'b0, md});
    c = 0;
    while (ms_tick !== 1'b1 && c < 6000) begin
      @(negedge clock);
      c++;
    end
    c = 0;
    do begin
      @(negedge clock);
      c++;
    end while (ms_tick !== 1'b1 && c < 6000);
    chk(c, 5000);
    rx_error = 1'b1;
    @(negedge clock);
    rx_error = 1'b0;
    cfg(0, 8'h80, 0, 33'h0800_0801);
    cfg(0, 8'h80, 0, 33'h801);
    cfg(1, 8'h80, 32'h1805, 33'h0);
    cfg(0, 8'h80, 0, 33'h1805);
    cfg(1, 8'h80, 32'h0100_1805, 33'h0);
    tog();
    tog();
    chk(c, 3);
    repeat (40) @(negedge clock);
    cfg(0, 8'h80, 0, 33'h0200_1805);
    hello_cmd = 1'b1;
    @(negedge clock);
    hello_cmd = 1'b0;
    tx_token_req = 1'b1;
    c = 0;
    while (tx_token_ack !== 1'b1 && c < 200) begin
      @(negedge clock);
      c++;
    end
    tx_token_req = 1'b0;
    chk(tx_token_ack, 1'b1);
    repeat (4) tog();
    chk(c, 5);
    repeat (60) @(negedge clock);
    cfg(0, 8'h80, 0, 33'h0600_1805);
    cfg(1, 8'h80, 32'h0080_1805, 33'h0);
    chk(n_sync, 1);
    for (int k = 0; k < 4; k++) begin
      cfg(1, 8'h51, 32'h7, 33'h0);
      if (k == 0) cfg(1, 8'h50, 32'h1, 33'h0);
      else begin
        wdog_expire = (k == 1);
        ext_rst_pin_n = (k != 2);
        brownout_pin = (k == 3);
        @(negedge clock);
        {wdog_expire, brownout_pin, ext_rst_pin_n} = 3'h1;
      end
      meas();
      chk(ns >= 64 && ns <= 66 && nt >= ns, 1'b1);
      cfg(0, 8'h51, 0, 33'h19);
    end
    chk(exp_q.size(), 0);
    test_done();
  end
endmodule

// *** testbench/anrl_remote_end.sv ***
`timescale 1ns/1ps
module anrl_remote_end (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic link_tx_wire,
  input wire logic hello_cmd,
  output logic rx_hello,
  output logic rx_credit
);
  logic wire_q;
  logic [1:0] edges_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wire_q <= 1'b0;
      edges_q <= 2'h0;
      rx_credit <= 1'b0;
      rx_hello <= 1'b0;
    end else begin
      wire_q <= link_tx_wire;
      rx_hello <= hello_cmd;
      rx_credit <= (wire_q != link_tx_wire) && (edges_q == 2'h3);
      if (wire_q != link_tx_wire) begin
        edges_q <= edges_q + 2'h1;
      end
    end
  end
endmodule
